// File: sscb_params.svh
// Constants of the synchronous SRAM burst command logic.
// Assumes inclusion by bare name from the package and the modules.
`ifndef SSCB_PARAMS_SVH
`define SSCB_PARAMS_SVH
`define SSCB_LANE_W 9
`define SSCB_LANES 4
`define SSCB_ADDR_W 18
`define SSCB_ST_IDLE 2'b00
`define SSCB_ST_READ 2'b01
`define SSCB_ST_WRITE 2'b11
// Sync reset: order select high, output enable off, not asleep
`define SSCB_SYNC_RST 3'h6
`define SSCB_LOW_RST 2'h0
`define SSCB_SEQ_STEP 2'h1
`endif

// File: sscb_pkg.sv
// Types shared by the burst command logic modules.
// Assumes sscb_params.svh is on the include path.
`include "sscb_params.svh"
package sscb_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = `SSCB_ST_IDLE,
    ST_READ = `SSCB_ST_READ,
    ST_WRITE = `SSCB_ST_WRITE
  } sscb_state_e;
  typedef logic [1:0] sscb_low_t;
endpackage

// File: sscb_mem_if.sv
// Array port between the command logic and the lane-masked array.
// Assumes both ends run on clk_sys.
`timescale 1ns/100ps
`default_nettype none
interface sscb_mem_if #(
  parameter int AW = 18,
  parameter int LANES = 4,
  parameter int DW = 36
);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [LANES-1:0] wr_lanes;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport ctrl (output wr_en, wr_addr, wr_lanes, wr_data, rd_addr, input rd_data);
  modport ram (input wr_en, wr_addr, wr_lanes, wr_data, rd_addr, output rd_data);
endinterface
`default_nettype wire

// File: sscb_burst_ctr.sv
// Two-bit burst address counter, linear or interleaved order.
// Assumes load and advance are never high together.
`timescale 1ns/100ps
`default_nettype none
`include "sscb_params.svh"
module sscb_burst_ctr (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic step_en,
  input wire logic load,
  input wire logic advance,
  input wire sscb_pkg::sscb_low_t load_low,
  input wire logic interleaved,
  output sscb_pkg::sscb_low_t cur_low,
  output sscb_pkg::sscb_low_t next_low
);
  import sscb_pkg::*;
  sscb_low_t base_reg;
  sscb_low_t seq_reg;
  sscb_low_t seq_inc;

  assign seq_inc = seq_reg + `SSCB_SEQ_STEP;
  // ==============================================================
  // Address order
  assign cur_low = interleaved ? (base_reg ^ seq_reg) : (base_reg + seq_reg);
  assign next_low = interleaved ? (base_reg ^ seq_inc) : (base_reg + seq_inc); // [RULE_16] [RULE_17]

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      base_reg <= `SSCB_LOW_RST;
      seq_reg <= `SSCB_LOW_RST;
    end else if (step_en && load) begin
      base_reg <= load_low;
      seq_reg <= `SSCB_LOW_RST;
    end else if (step_en && advance) begin
      seq_reg <= seq_inc; // [RULE_12]
    end
  end

  // ==============================================================
  // Checks
  chk_count_step: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_12]
    step_en && advance && !load |=> seq_reg == $past(seq_reg) + 2'h1)
    else $error("burst counter did not step");
  chk_linear_order: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_16]
    step_en && advance && !load && !interleaved ##1 !interleaved
      |-> cur_low == $past(cur_low) + 2'h1)
    else $error("linear burst order wrong");
  chk_interleave_order: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE_17]
    step_en && advance && !load && interleaved ##1 interleaved
      |-> (cur_low ^ base_reg) == $past(seq_reg) + 2'h1)
    else $error("interleaved burst order wrong");
endmodule
`default_nettype wire

// File: sscb_lane_ram.sv
// Storage array with per-lane write masking and asynchronous read.
// Assumes the controller gates wr_en with its clock enable.
`timescale 1ns/100ps
`default_nettype none
`include "sscb_params.svh"
module sscb_lane_ram #(
  parameter int AW = 18,
  parameter int LANES = 4,
  parameter int DW = 36
) (
  input wire logic clk_sys,
  sscb_mem_if.ram m
);
  import sscb_pkg::*;
  localparam int LW = `SSCB_LANE_W;
  logic [DW-1:0] mem [0:(1<<AW)-1];

  assign m.rd_data = mem[m.rd_addr];

  // Any subset of lanes is written; the rest keep their bytes
  always_ff @(posedge clk_sys) begin
    for (int l = 0; l < LANES; l++) begin
      if (m.wr_en && m.wr_lanes[l]) begin
        mem[m.wr_addr][l*LW +: LW] <= m.wr_data[l*LW +: LW]; // [RULE_11] [RULE_13] [RULE_14] [RULE_15]
      end
    end
  end
endmodule
`default_nettype wire

// File: sscb_top.sv
// Cycle decode, burst sequencing and data path of a flow-through
// zero-latency synchronous SRAM.
// Assumes the controller is synchronous to clk_sys; output enable,
// sleep and order select are asynchronous and are synchronised here.
//
// Summary of operation
// [RULE_01] Burst type fixed at load, continues repeat it
// [RULE_02] Continue-deselect only after deselect, stays Hi-Z
// [RULE_03] Read with output enable off drives nothing
// [RULE_04] Write with all lanes off aborts
// [RULE_05] Write cycles turn data drivers off
// [RULE_06] Controller may tie output enable low
// [RULE_07] Stalled read keeps data bus driven
// [RULE_08] Stalled write keeps data bus Hi-Z
// [RULE_09] Stalled edge writes nothing, holds state
// [RULE_10] Write active when any lane enable low
// [RULE_11] Each lane enable gates its own byte
// [RULE_12] Counter steps on every continue cycle
// [RULE_13] Any lane subset writable in one cycle
// [RULE_14] Two-lane organisation read/write lane decode
// [RULE_15] Four-lane organisation read/write lane decode
// [RULE_16] Order low: low bits count up mod four
// [RULE_17] Order high: low bits XOR sequence count
// [RULE_18] Any inactive select at load deselects
// [RULE_19] All selects active at load start burst
// [RULE_20] Read drives current burst word flow-through
// [RULE_21] Sleep ignores inputs, data bus Hi-Z
// [RULE_22] Order select static, type changes by load
// [RULE_23] Read after write returns newest data
`timescale 1ns/100ps
`default_nettype none
`include "sscb_params.svh"
module sscb_top #(
  parameter int LANES = `SSCB_LANES,
  parameter int ADDR_W = `SSCB_ADDR_W,
  localparam int DW = LANES * `SSCB_LANE_W
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] address,
  input wire logic select_n,
  input wire logic depth_select_high,
  input wire logic depth_select_low,
  input wire logic advance_not_load,
  input wire logic read_not_write,
  input wire logic [LANES-1:0] lane_write_enables_n,
  input wire logic out_enable_n,
  input wire logic clock_gate_n,
  input wire logic sleep_request,
  input wire logic burst_order_mode,
  input wire logic [DW-1:0] data_in,
  output logic [DW-1:0] data_out,
  output logic data_oe
);
  import sscb_pkg::*;
  localparam int LW = `SSCB_LANE_W;

  // ==============================================================
  // Asynchronous pins
  logic [2:0] async_in;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic asleep;
  logic oe_n_s;
  logic interleaved;

  assign async_in = {burst_order_mode, out_enable_n, sleep_request};

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sync1_reg <= `SSCB_SYNC_RST;
      sync2_reg <= `SSCB_SYNC_RST;
    end else if (clk_en) begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end

  assign asleep = sync2_reg[0];
  assign oe_n_s = sync2_reg[1];
  // Order select is only sampled, so it must stay static while busy
  assign interleaved = sync2_reg[2]; // [RULE_22]

  // ==============================================================
  // Cycle decode
  sscb_state_e state_reg;
  sscb_state_e state_next;
  sscb_state_e load_state;
  logic chip_sel;
  logic accept;
  logic stall;
  logic do_load;
  logic do_desel;
  logic do_cont;
  logic any_lane;
  logic cyc_write;
  logic cyc_read;
  logic write_live;
  logic [ADDR_W-1:0] cyc_addr;
  logic [ADDR_W-3:0] upper_reg;
  sscb_low_t cur_low;
  sscb_low_t next_low;

  assign chip_sel = ~select_n & depth_select_high & ~depth_select_low;
  // Sleep masks every edge, so no command or data pin is sampled meanwhile
  assign accept = clk_en & ~clock_gate_n & ~asleep; // [RULE_21]
  assign stall = clk_en & clock_gate_n & ~asleep; // [RULE_09]
  assign do_load = accept & ~advance_not_load & chip_sel; // [RULE_19]
  assign do_desel = accept & ~advance_not_load & ~chip_sel; // [RULE_18]
  // From idle an advance stays deselected
  assign do_cont = accept & advance_not_load & (state_reg != ST_IDLE); // [RULE_02]
  assign any_lane = ~&lane_write_enables_n; // [RULE_10]
  assign load_state = read_not_write ? ST_READ : ST_WRITE; // [RULE_14] [RULE_15]
  // Continue cycles ignore read_not_write
  assign cyc_write = do_load ? ~read_not_write : (do_cont & (state_reg == ST_WRITE)); // [RULE_01]
  assign cyc_read = do_load ? read_not_write : (do_cont & (state_reg == ST_READ)); // [RULE_01]
  assign write_live = cyc_write & any_lane; // [RULE_04]
  assign cyc_addr = do_load ? address : {upper_reg, next_low};

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (do_load) begin
          state_next = load_state;
        end
      end
      ST_READ, ST_WRITE: begin
        if (do_load) begin
          state_next = load_state;
        end else if (do_desel) begin
          state_next = ST_IDLE; // [RULE_18]
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (asleep) begin
      state_next = ST_IDLE;
    end
  end

  sscb_burst_ctr u_ctr (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .step_en(accept),
    .load(do_load),
    .advance(do_cont), // [RULE_12]
    .load_low(address[1:0]),
    .interleaved(interleaved),
    .cur_low(cur_low),
    .next_low(next_low)
  );

  // ==============================================================
  // Write pipeline and array
  // Write data follows its address by one accepted edge, so the
  // lanes and address wait here until the data arrives.
  logic pend_valid_reg;
  logic [ADDR_W-1:0] pend_addr_reg;
  logic [LANES-1:0] pend_lanes_reg;
  logic rd_drive_reg;
  logic [DW-1:0] data_out_reg;
  logic [DW-1:0] merged;
  logic bypass_hit;

  sscb_mem_if #(.AW(ADDR_W), .LANES(LANES), .DW(DW)) mif ();

  // A stalled edge never reaches the array
  assign mif.wr_en = accept & pend_valid_reg; // [RULE_09]
  assign mif.wr_addr = pend_addr_reg;
  assign mif.wr_lanes = pend_lanes_reg; // [RULE_11]
  assign mif.wr_data = data_in;
  assign mif.rd_addr = cyc_addr;

  sscb_lane_ram #(.AW(ADDR_W), .LANES(LANES), .DW(DW)) u_ram (
    .clk_sys(clk_sys),
    .m(mif.ram)
  );

  assign bypass_hit = mif.wr_en & (pend_addr_reg == cyc_addr);

  // Array is written at this same edge, so the read takes the
  // arriving bytes straight from the data pins
  for (genvar l = 0; l < LANES; l++) begin : g_merge
    assign merged[l*LW +: LW] = (bypass_hit && pend_lanes_reg[l]) ?
      data_in[l*LW +: LW] : mif.rd_data[l*LW +: LW]; // [RULE_23]
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      rd_drive_reg <= 1'b0;
      pend_valid_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      if (asleep) begin
        rd_drive_reg <= 1'b0;
        pend_valid_reg <= 1'b0;
      end else if (accept) begin
        rd_drive_reg <= cyc_read;
        pend_valid_reg <= write_live; // [RULE_04] [RULE_10]
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pend_addr_reg <= '0;
      pend_lanes_reg <= '0;
      upper_reg <= '0;
      data_out_reg <= '0;
    end else if (accept) begin
      pend_addr_reg <= cyc_addr;
      pend_lanes_reg <= ~lane_write_enables_n; // [RULE_13]
      if (do_load) begin
        upper_reg <= address[ADDR_W-1:2];
      end
      if (cyc_read) begin
        data_out_reg <= merged; // [RULE_20]
      end
    end
  end

  // ==============================================================
  // Data pins
  // Drive only for read cycles; a stalled edge holds the last cycle
  assign data_out = data_out_reg;
  assign data_oe = rd_drive_reg & ~oe_n_s & ~asleep; // [RULE_03] [RULE_05] [RULE_07] [RULE_08]

  // ==============================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  chk_write_no_drive: assert property ( // [RULE_05]
    state_reg == ST_WRITE |-> !data_oe)
    else $error("data driven during write");
  chk_cont_same_type: assert property ( // [RULE_01]
    do_cont |=> state_reg == $past(state_reg))
    else $error("continue cycle changed burst type");
  chk_abort_no_write: assert property ( // [RULE_04]
    cyc_write && !any_lane |=> !pend_valid_reg && !data_oe)
    else $error("write abort scheduled a write");
  chk_stall_no_write: assert property ( // [RULE_09]
    stall |-> !mif.wr_en)
    else $error("array written on stalled edge");
  chk_stall_holds: assert property ( // [RULE_09]
    stall |=> $stable(state_reg) && $stable(data_out) && $stable(pend_valid_reg))
    else $error("state moved on stalled edge");
  chk_stall_read_drive: assert property ( // [RULE_07]
    rd_drive_reg && stall |=> rd_drive_reg)
    else $error("stalled read dropped drive");
  chk_dummy_read_hiz: assert property ( // [RULE_03]
    oe_n_s |-> !data_oe)
    else $error("driven with output enable off");
  chk_sleep_hiz: assert property ( // [RULE_21]
    clk_en && asleep |=> state_reg == ST_IDLE && !data_oe)
    else $error("sleep did not deselect");
  chk_cont_deselect: assert property ( // [RULE_02]
    state_reg == ST_IDLE && accept && advance_not_load
      |=> state_reg == ST_IDLE && !rd_drive_reg)
    else $error("continue deselect left idle");
  chk_load_type: assert property ( // [RULE_19]
    do_load |=> state_reg == ($past(read_not_write) ? ST_READ : ST_WRITE))
    else $error("load chose wrong burst type");
  chk_deselect_idle: assert property ( // [RULE_18]
    do_desel |=> state_reg == ST_IDLE && !rd_drive_reg)
    else $error("deselect not taken");
  chk_bypass_newest: assert property ( // [RULE_23]
    cyc_read && bypass_hit && pend_lanes_reg[0]
      |=> data_out[LW-1:0] == $past(data_in[LW-1:0]))
    else $error("read after write returned stale data");
  // Write pipeline, read word, load path, stall and sleep
  chk_lane_any_live: assert property ( // [RULE_10]
    cyc_write |=> pend_valid_reg == $past(any_lane))
    else $error("write not live with a lane enabled");
  chk_lane_subset: assert property ( // [RULE_13]
    write_live |=> pend_lanes_reg == ~$past(lane_write_enables_n))
    else $error("pending lane mask wrong");
  chk_read_word: assert property ( // [RULE_20]
    cyc_read |=> rd_drive_reg && data_out == $past(merged))
    else $error("read word not presented");
  chk_stall_write_hiz: assert property ( // [RULE_08]
    state_reg == ST_WRITE && stall |=> !data_oe)
    else $error("stalled write drove data bus");
  chk_load_address: assert property ( // [RULE_19]
    do_load |=> cur_low == $past(address[1:0]) && upper_reg == $past(address[ADDR_W-1:2]))
    else $error("load did not take external address");
  chk_sleep_drops: assert property ( // [RULE_21]
    clk_en && asleep |=> !pend_valid_reg && !rd_drive_reg)
    else $error("sleep kept a pending cycle");
  chk_write_no_read: assert property ( // [RULE_05]
    cyc_write |=> !rd_drive_reg)
    else $error("write cycle set read drive");
  chk_desel_no_write: assert property ( // [RULE_18]
    do_desel |=> !pend_valid_reg)
    else $error("deselect scheduled a write");
  chk_stall_pending: assert property ( // [RULE_09]
    stall |=> $stable(pend_addr_reg) && $stable(upper_reg))
    else $error("stalled edge moved pending address");
endmodule
`default_nettype wire

// File: sscb_host.sv
// Host memory controller model driving the SRAM command and data pins.
// Assumes clk_sys comes from the bench; pins move only on falling edges.
`timescale 1ns/100ps
`default_nettype none
module sscb_host (
  input wire logic clk_sys,
  output logic [17:0] address,
  output logic select_n,
  output logic depth_select_high,
  output logic depth_select_low,
  output logic advance_not_load,
  output logic read_not_write,
  output logic [3:0] lane_write_enables_n,
  output logic out_enable_n,
  output logic clock_gate_n,
  output logic sleep_request,
  output logic burst_order_mode,
  output logic [35:0] data_in
);
  // ==========================================
  // Pin drivers
  initial begin
    address = 18'h0;
    {select_n, depth_select_high, depth_select_low} = 3'b110;
    advance_not_load = 1'b0;
    read_not_write = 1'b1;
    lane_write_enables_n = 4'hf;
    out_enable_n = 1'b0;
    clock_gate_n = 1'b0;
    sleep_request = 1'b0;
    burst_order_mode = 1'b1;
    data_in = 36'h0;
  end
  // One bus cycle; held through the rising edge, result readable on return
  task automatic cyc(input logic adv, input logic rnw, input logic [17:0] a,
                     input logic [3:0] ln, input logic [35:0] d, input logic [2:0] cs,
                     input logic cg);
    @(negedge clk_sys);
    advance_not_load = adv;
    read_not_write = rnw;
    address = a;
    lane_write_enables_n = ln;
    data_in = d;
    {select_n, depth_select_high, depth_select_low} = cs;
    clock_gate_n = cg;
    @(posedge clk_sys);
    #1;
  endtask
  // Mode only ever changes on the falling edge just before the device is reset
  task automatic pins(input logic oe_n, input logic slp, input logic md);
    @(negedge clk_sys);
    out_enable_n = oe_n;
    sleep_request = slp;
    burst_order_mode = md;
  endtask
endmodule
`default_nettype wire

// File: sync_sram_burst_command_logic_test.sv
// Self-checking bench for the burst command logic top.
// Assumes sscb_host as the controller model, default widths (4 lanes) for dut_u and 2 lanes for dut_u2.
`timescale 1ns/100ps
`default_nettype none
module sync_sram_burst_command_logic_test;
  localparam logic [2:0] CS_ON = 3'b010;
  localparam logic [2:0] CS_OFF = 3'b110;
  logic clk_sys;
  logic rstn;
  logic [17:0] address;
  logic select_n, depth_select_high, depth_select_low, advance_not_load;
  logic read_not_write, out_enable_n, clock_gate_n, sleep_request, burst_order_mode;
  logic [3:0] lane_write_enables_n;
  logic [35:0] data_in, data_out;
  logic data_oe;
  logic [17:0] data_out_x2;
  int num_errors;
  int num_checks;
  // ==========================================
  // Structure
  sscb_host h (.clk_sys(clk_sys), .address(address), .select_n(select_n),
    .depth_select_high(depth_select_high), .depth_select_low(depth_select_low),
    .advance_not_load(advance_not_load), .read_not_write(read_not_write),
    .lane_write_enables_n(lane_write_enables_n), .out_enable_n(out_enable_n),
    .clock_gate_n(clock_gate_n), .sleep_request(sleep_request),
    .burst_order_mode(burst_order_mode), .data_in(data_in));
  sscb_top dut_u (.clk_sys(clk_sys), .rstn(rstn), .clk_en(1'b1), .address(address),
    .select_n(select_n), .depth_select_high(depth_select_high),
    .depth_select_low(depth_select_low), .advance_not_load(advance_not_load),
    .read_not_write(read_not_write), .lane_write_enables_n(lane_write_enables_n),
    .out_enable_n(out_enable_n), .clock_gate_n(clock_gate_n),
    .sleep_request(sleep_request), .burst_order_mode(burst_order_mode),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
  // Two-lane organisation on the low half of the same bus
  sscb_top #(.LANES(2)) dut_u2 (.clk_sys(clk_sys), .rstn(rstn), .clk_en(1'b1),
    .address(address), .select_n(select_n), .depth_select_high(depth_select_high),
    .depth_select_low(depth_select_low), .advance_not_load(advance_not_load),
    .read_not_write(read_not_write), .lane_write_enables_n(lane_write_enables_n[1:0]),
    .out_enable_n(out_enable_n), .clock_gate_n(clock_gate_n),
    .sleep_request(sleep_request), .burst_order_mode(burst_order_mode),
    .data_in(data_in[17:0]), .data_out(data_out_x2), .data_oe());
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ==========================================
  // Helpers
  function automatic logic [35:0] pat(input logic [17:0] a);
    pat = {a, ~a};
  endfunction
  function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
                                        input logic [3:0] ln);
    merge = o;
    for (int l = 0; l < 4; l++) begin
      if (!ln[l]) begin
        merge[l*9 +: 9] = n[l*9 +: 9];
      end
    end
  endfunction
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(negedge clk_sys);
    rstn = 1'b0;
    repeat (16) @(negedge clk_sys);
    rstn = 1'b1;
  endtask
  task automatic idle(input int n);
    repeat (n) h.cyc(1'b0, 1'b1, 18'h0, 4'hf, 36'h0, CS_OFF, 1'b0);
  endtask
  // Data phase is a deselect cycle, so the write lands before the next command
  task automatic wr(input logic [17:0] a, input logic [3:0] ln, input logic [35:0] d);
    h.cyc(1'b0, 1'b0, a, ln, ~d, CS_ON, 1'b0);
    chk(36'(data_oe), 36'h0);
    h.cyc(1'b0, 1'b1, 18'h0, 4'hf, d, CS_OFF, 1'b0);
    chk(36'(data_oe), 36'h0);
  endtask
  task automatic rd(input logic [17:0] a, input logic [35:0] exp);
    h.cyc(1'b0, 1'b1, a, 4'h0, 36'h0, CS_ON, 1'b0);
    chk(data_out, exp);
    chk(36'(data_oe), 36'h1);
  endtask
  // ==========================================
  // Scenarios
  task automatic s_burst(input logic md, input logic [7:0] seq);
    logic [17:0] a;
    h.pins(1'b0, 1'b0, md);
    do_reset();
    for (int i = 0; i < 4; i++) begin
      wr(18'h100 + 18'(i), 4'h0, pat(18'h100 + 18'(i)));
    end
    // Continues carry write and a wild address: both must be ignored
    for (int i = 0; i < 4; i++) begin
      a = {16'h0040, seq[7-2*i -: 2]};
      h.cyc(i != 0, i == 0, (i == 0) ? 18'h101 : 18'h3ffff, 4'h0, 36'h0, CS_ON, 1'b0);
      chk(data_out, pat(a));
    end
  endtask
  task automatic s_lanes();
    logic [3:0] tbl [6] = '{4'he, 4'hd, 4'hb, 4'h7, 4'ha, 4'h0};
    logic [35:0] exp;
    foreach (tbl[k]) begin
      exp = merge(pat(18'h200), ~pat(18'h200), tbl[k]);
      wr(18'h200, 4'h0, pat(18'h200));
      wr(18'h200, tbl[k], ~pat(18'h200));
      rd(18'h200, exp);
      chk({18'h0, data_out_x2}, {18'h0, exp[17:0]});
    end
    // Abort leaves the last all-lane word in place
    wr(18'h200, 4'hf, 36'h0);
    rd(18'h200, exp);
    chk({18'h0, data_out_x2}, {18'h0, exp[17:0]});
  endtask
  task automatic s_stall();
    wr(18'h300, 4'h0, pat(18'h300));
    rd(18'h300, pat(18'h300));
    h.cyc(1'b0, 1'b1, 18'h0, 4'h0, 36'h0, CS_ON, 1'b1);
    chk(data_out, pat(18'h300));
    chk(36'(data_oe), 36'h1);
    h.cyc(1'b0, 1'b0, 18'h300, 4'h0, 36'h5, CS_ON, 1'b0);
    h.cyc(1'b0, 1'b1, 18'h0, 4'hf, 36'h5, CS_OFF, 1'b1);
    chk(36'(data_oe), 36'h0);
    h.cyc(1'b0, 1'b1, 18'h0, 4'hf, 36'h9, CS_OFF, 1'b0);
    rd(18'h300, 36'h9);
  endtask
  task automatic s_quiet();
    logic [2:0] cs [3] = '{3'b110, 3'b000, 3'b011};
    h.pins(1'b1, 1'b0, 1'b1);
    idle(2);
    h.cyc(1'b0, 1'b1, 18'h300, 4'h0, 36'h0, CS_ON, 1'b0);
    chk(36'(data_oe), 36'h0);
    h.pins(1'b0, 1'b1, 1'b1);
    idle(3);
    h.cyc(1'b0, 1'b1, 18'h300, 4'h0, 36'h0, CS_ON, 1'b0);
    chk(36'(data_oe), 36'h0);
    h.pins(1'b0, 1'b0, 1'b1);
    idle(3);
    foreach (cs[k]) begin
      rd(18'h300, 36'h9);
      h.cyc(1'b0, 1'b1, 18'h300, 4'h0, 36'h0, cs[k], 1'b0);
      chk(36'(data_oe), 36'h0);
      h.cyc(1'b1, 1'b1, 18'h300, 4'h0, 36'h0, cs[k], 1'b0);
      chk(36'(data_oe), 36'h0);
    end
  endtask
  task automatic s_bypass();
    h.cyc(1'b0, 1'b0, 18'h300, 4'h0, 36'h0, CS_ON, 1'b0);
    h.cyc(1'b0, 1'b1, 18'h300, 4'hf, 36'h123456789, CS_ON, 1'b0);
    chk(data_out, 36'h123456789);
  endtask
  // Interleaved write burst; continues carry read and a wild address,
  // the third cycle aborts yet the counter must still step
  task automatic s_wburst();
    logic [17:0] wa [4];
    logic [3:0] ln;
    for (int i = 0; i < 4; i++) begin
      wa[i] = {16'h0100, 2'(i) ^ 2'b10};
    end
    wr(wa[2], 4'h0, 36'h0);
    h.cyc(1'b0, 1'b0, wa[0], 4'h0, 36'h0, CS_ON, 1'b0);
    for (int i = 1; i < 4; i++) begin
      ln = (i == 2) ? 4'hf : 4'h0;
      h.cyc(1'b1, 1'b1, 18'h3ffff, ln, pat(wa[i-1]), CS_ON, 1'b0);
      chk(36'(data_oe), 36'h0);
    end
    h.cyc(1'b0, 1'b1, 18'h0, 4'hf, pat(wa[3]), CS_OFF, 1'b0);
    for (int i = 0; i < 4; i++) begin
      rd(wa[i], (i == 2) ? 36'h0 : pat(wa[i]));
    end
  endtask
  // ==========================================
  // Main sequence
  initial begin
    rstn = 1'b0;
    num_errors = 0;
    num_checks = 0;
    s_burst(1'b0, 8'b01_10_11_00);
    s_burst(1'b1, 8'b01_00_11_10);
    s_lanes();
    s_stall();
    s_quiet();
    s_bypass();
    s_wburst();
    close_out();
  end
  // Guard against a hang in any scenario
  initial begin
    #500us;
    num_errors++;
    close_out();
  end
endmodule
`default_nettype wire
